// *** rtl/boot_mode_selector.sv ***
`timescale 1ns/1ps
module boot_mode_selector
  import boot_sel_pkg::*;
#(
  parameter logic [TMR_W-1:0] REPRESS_CYC = CYC_REPRESS,
  parameter logic [TMR_W-1:0] HOLD_MIN_CYC = CYC_HOLD_MIN,
  parameter logic [TMR_W-1:0] HOLD_MAX_CYC = CYC_HOLD_MAX,
  parameter logic [TMR_W-1:0] SWITCH_CYC = CYC_SWITCH,
  parameter logic [TMR_W-1:0] DEBOUNCE_CYC = CYC_DEBOUNCE,
  parameter logic [FLASH_W-1:0] FLASH_HALF_CYC = CYC_FLASH_HALF
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Operator button, high while pressed
  input wire logic btn_i,
  // Stored boot mode
  input wire logic nvm_valid_i,
  input wire boot_mode_t nvm_mode_i,
  output nvm_wr_t nvm_wr_o,
  // Decoded fieldbus object writes
  input wire sdo_wr_t sdo_wr_i,
  output logic save_dev_o,
  output logic save_meas_o,
  // Setup interface
  input wire logic setup_fb_sel_i,
  output logic setup_drop_o,
  // Firmware switch and restart
  output logic fw_switch_o,
  input wire logic fw_done_i,
  output logic reboot_o,
  output boot_mode_t boot_mode_o,
  // Indicator
  output led_t status_indicator_led_o
);

  sel_state_t state;
  sel_state_t next_state;
  logic [TMR_W-1:0] timer;
  logic [TMR_W-1:0] next_timer;
  logic [FLASH_W-1:0] flash_cnt;
  logic flash_phase;
  logic btn_db;

  // Filtered button level
  btn_debounce #(
    .STABLE_CYC(DEBOUNCE_CYC)
  ) u_debounce (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .raw_i(btn_i),
    .clean_o(btn_db)
  );

  // Timer expiry decodes
  wire boot_hit = timer == DEBOUNCE_CYC;
  wire repress_hit = timer == REPRESS_CYC - 33'h1;
  wire hold_min_hit = timer == HOLD_MIN_CYC - 33'h1;
  wire hold_max_hit = timer == HOLD_MAX_CYC - 33'h1;
  wire switch_hit = timer == SWITCH_CYC - 33'h1;
  wire flash_tick = flash_cnt == FLASH_HALF_CYC - 24'h1;

  // Object dictionary decodes; the SDO protocol itself lives upstream
  wire save_dev_hit = sdo_wr_i.valid && sdo_wr_i.index == OBJ_SAVE_DEV_IDX
                      && sdo_wr_i.sub == OBJ_SAVE_DEV_SUB;
  wire save_meas_hit = sdo_wr_i.valid && sdo_wr_i.index == OBJ_SAVE_MEAS_IDX
                       && sdo_wr_i.sub == OBJ_SAVE_MEAS_SUB;

  // A setup request is meaningful only while running in setup mode
  wire setup_req = state == S_RUN && setup_fb_sel_i && boot_mode_o == MODE_SETUP;
  wire switch_end = state == S_SWITCH && (fw_done_i || switch_hit);
  wire stored_mode_fb = nvm_valid_i ? (nvm_mode_i == MODE_FIELDBUS) : 1'b1;

  always_comb begin
    next_state = state;
    case (state)
      // Debouncer needs one full interval before the power-up level is trusted
      S_BOOT: begin
        if (boot_hit) begin
          next_state = btn_db ? S_REL_WAIT : S_RUN;
        end
      end
      S_RUN: begin
        if (setup_req) begin
          next_state = S_SWITCH;
        end
      end
      S_REL_WAIT: begin
        if (!btn_db) begin
          next_state = S_WAIT_PRESS;
        end
      end
      S_WAIT_PRESS: begin
        if (btn_db) begin
          next_state = S_HOLD;
        end else if (repress_hit) begin
          next_state = S_RUN;
        end
      end
      S_HOLD: begin
        if (!btn_db) begin
          next_state = S_RUN;
        end else if (hold_min_hit) begin
          next_state = S_RED;
        end
      end
      // Timer keeps running from the start of the second press
      S_RED: begin
        if (!btn_db) begin
          next_state = S_SWITCH;
        end else if (hold_max_hit) begin
          next_state = S_RUN;
        end
      end
      S_SWITCH: begin
        if (switch_end) begin
          next_state = S_REBOOT;
        end
      end
      S_REBOOT: begin
        next_state = S_BOOT;
      end
      default: begin
        next_state = S_BOOT;
      end
    endcase
  end

  // Timer restarts on every state change except hold into red
  wire timer_clear = (next_state != state && next_state != S_RED) || state == S_RUN;
  assign next_timer = timer_clear ? '0 : timer + 33'h1;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= S_BOOT;
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // Single 8 Hz flash source shared by both colours
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flash_cnt <= '0;
      flash_phase <= 1'b0;
    end else begin
      flash_cnt <= flash_tick ? '0 : flash_cnt + 24'h1;
      flash_phase <= flash_phase ^ flash_tick;
    end
  end

  wire yellow_state = next_state == S_REL_WAIT || next_state == S_WAIT_PRESS
                      || next_state == S_HOLD || next_state == S_SWITCH;
  wire red_state = next_state == S_RED;
  wire next_phase = flash_phase ^ flash_tick;

  // Boot mode: captured once the power-up check finishes, forced by a switch
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_mode_o <= RST_BOOT_MODE;
    end else if (state == S_BOOT && boot_hit) begin
      boot_mode_o <= stored_mode_fb ? MODE_FIELDBUS : MODE_SETUP;
    end else if (switch_end) begin
      boot_mode_o <= MODE_FIELDBUS;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_indicator_led_o <= '0;
      save_dev_o <= 1'b0;
      save_meas_o <= 1'b0;
      setup_drop_o <= 1'b0;
      fw_switch_o <= 1'b0;
      reboot_o <= 1'b0;
      nvm_wr_o <= '0;
    end else begin
      status_indicator_led_o.yellow <= yellow_state && next_phase;
      status_indicator_led_o.red <= red_state && next_phase;
      save_dev_o <= save_dev_hit;
      save_meas_o <= save_meas_hit;
      setup_drop_o <= setup_req;
      fw_switch_o <= next_state == S_SWITCH;
      reboot_o <= switch_end;
      nvm_wr_o.req <= switch_end;
      nvm_wr_o.mode <= MODE_FIELDBUS;
    end
  end

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_default_mode: assert property (
    state == S_BOOT && boot_hit && !nvm_valid_i |=> boot_mode_o == MODE_FIELDBUS)
    else $error("boot mode did not default to fieldbus");

  a_stored_mode: assert property (
    state == S_BOOT && boot_hit && nvm_valid_i |=> boot_mode_o == $past(nvm_mode_i))
    else $error("boot mode differs from stored mode");

  a_yellow_start: assert property (
    state == S_BOOT && boot_hit && btn_db |=> state == S_REL_WAIT && !status_indicator_led_o.red)
    else $error("held button at power-up did not start yellow flashing");

  a_red_after_hold: assert property (
    state == S_HOLD && btn_db && hold_min_hit |=> state == S_RED)
    else $error("red flashing did not start after hold time");

  a_red_only_red: assert property (
    status_indicator_led_o.red |-> state == S_RED && !status_indicator_led_o.yellow)
    else $error("red indicator outside red phase");

  a_release_yellow: assert property (
    state == S_RED && !btn_db |=> state == S_SWITCH ##0 fw_switch_o)
    else $error("release during red did not start the switch");

  a_switch_bound: assert property (
    state == S_SWITCH |-> timer < SWITCH_CYC)
    else $error("mode switch exceeded its time limit");

  a_reboot_mode: assert property (
    reboot_o |-> boot_mode_o == MODE_FIELDBUS && nvm_wr_o.req ##1 state == S_BOOT)
    else $error("reboot without fieldbus mode");

  a_save_dev: assert property (
    save_dev_hit |=> save_dev_o && !save_meas_o)
    else $error("device settings save not issued");

  a_save_meas: assert property (
    save_meas_hit |=> save_meas_o && !save_dev_o)
    else $error("measurement settings save not issued");

  a_setup_drop: assert property (
    setup_req |=> setup_drop_o && state == S_SWITCH ##1 !setup_drop_o)
    else $error("setup selection did not drop the session");

  a_debounce_rise: assert property (
    $rose(btn_db) |-> $past(btn_i, 1) && $past(btn_i, 2))
    else $error("filtered button rose without a stable press");

  a_repress_timeout: assert property (
    state == S_WAIT_PRESS && !btn_db && repress_hit |=> state == S_RUN
      && !status_indicator_led_o.yellow)
    else $error("late re-press did not abandon the sequence");

  a_short_release: assert property (
    state == S_HOLD && !btn_db |=> state == S_RUN && !fw_switch_o)
    else $error("release before hold time started a switch");

  a_hold_yellow: assert property (
    state == S_HOLD && btn_db && !hold_min_hit |=> state == S_HOLD && !status_indicator_led_o.red)
    else $error("red shown before the hold time elapsed");

  a_hold_abort: assert property (
    state == S_RED && btn_db && hold_max_hit |=> state == S_RUN && !status_indicator_led_o.red)
    else $error("overlong hold did not abandon the sequence");

  a_yellow_states: assert property (
    status_indicator_led_o.yellow |-> state inside {S_REL_WAIT, S_WAIT_PRESS, S_HOLD, S_SWITCH})
    else $error("yellow indicator outside a yellow phase");

  // The LED may only move on a flash tick or with the state, which keeps the rate fixed
  a_flash_steady: assert property (
    $changed(status_indicator_led_o) |-> $past(flash_tick) || $changed(state))
    else $error("indicator changed off the flash tick");

  a_fb_setup_ignored: assert property (
    state == S_RUN && boot_mode_o == MODE_FIELDBUS && setup_fb_sel_i |=> state == S_RUN
      && !setup_drop_o)
    else $error("setup request acted on while in fieldbus mode");

  a_switch_store: assert property (
    switch_end |=> reboot_o && nvm_wr_o.req && nvm_wr_o.mode == MODE_FIELDBUS && !fw_switch_o)
    else $error("switch end did not store fieldbus mode and reboot");

  a_fw_done: assert property (
    state == S_SWITCH && fw_done_i |=> state == S_REBOOT)
    else $error("finished firmware switch did not reboot");

  c_full_sequence: cover property (state == S_RED ##1 state == S_SWITCH);
  c_early_release: cover property (state == S_HOLD && !btn_db);
  c_setup_switch: cover property (setup_req);
  c_hold_abort: cover property (state == S_RED && hold_max_hit);
  c_repress_timeout: cover property (state == S_WAIT_PRESS && repress_hit && !btn_db);

endmodule : boot_mode_selector

// *** inc/boot_sel_pkg.sv ***
package boot_sel_pkg;

  // Clock and timing figures
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned T_REPRESS_MS = 15000;
  localparam int unsigned T_HOLD_MIN_MS = 10000;
  localparam int unsigned T_HOLD_MAX_MS = 15000;
  localparam int unsigned T_SWITCH_MS = 60000;
  localparam int unsigned T_DEBOUNCE_MS = 20;
  localparam int unsigned FLASH_HZ = 8;

  localparam int TMR_W = 33;
  localparam int FLASH_W = 24;

  // Derived cycle counts; the switch product exceeds 32 bits, so the timer counts are formed in 64 bits
  localparam logic [TMR_W-1:0] CYC_REPRESS = TMR_W'(64'(T_REPRESS_MS) * 64'(CYC_PER_MS));
  localparam logic [TMR_W-1:0] CYC_HOLD_MIN = TMR_W'(64'(T_HOLD_MIN_MS) * 64'(CYC_PER_MS));
  localparam logic [TMR_W-1:0] CYC_HOLD_MAX = TMR_W'(64'(T_HOLD_MAX_MS) * 64'(CYC_PER_MS));
  localparam logic [TMR_W-1:0] CYC_SWITCH = TMR_W'(64'(T_SWITCH_MS) * 64'(CYC_PER_MS));
  localparam logic [TMR_W-1:0] CYC_DEBOUNCE = TMR_W'(64'(T_DEBOUNCE_MS) * 64'(CYC_PER_MS));
  localparam logic [FLASH_W-1:0] CYC_FLASH_HALF = FLASH_W'(CLK_HZ / (2 * FLASH_HZ));

  // Object dictionary entries that commit settings
  localparam logic [15:0] OBJ_SAVE_DEV_IDX = 16'h3020;
  localparam logic [7:0] OBJ_SAVE_DEV_SUB = 8'h02;
  localparam logic [15:0] OBJ_SAVE_MEAS_IDX = 16'h3022;
  localparam logic [7:0] OBJ_SAVE_MEAS_SUB = 8'h03;

  typedef enum logic {
    MODE_SETUP = 1'b0,
    MODE_FIELDBUS = 1'b1
  } boot_mode_t;

  localparam boot_mode_t RST_BOOT_MODE = MODE_FIELDBUS;

  typedef enum logic [2:0] {
    S_BOOT = 3'b000,
    S_RUN = 3'b001,
    S_REL_WAIT = 3'b010,
    S_WAIT_PRESS = 3'b011,
    S_HOLD = 3'b100,
    S_RED = 3'b101,
    S_SWITCH = 3'b110,
    S_REBOOT = 3'b111
  } sel_state_t;

  typedef struct packed {
    logic valid;
    logic [15:0] index;
    logic [7:0] sub;
  } sdo_wr_t;

  typedef struct packed {
    logic yellow;
    logic red;
  } led_t;

  typedef struct packed {
    logic req;
    boot_mode_t mode;
  } nvm_wr_t;

endpackage : boot_sel_pkg

// *** rtl/btn_debounce.sv ***
`timescale 1ns/1ps
module btn_debounce
  import boot_sel_pkg::*;
#(
  parameter logic [TMR_W-1:0] STABLE_CYC = CYC_DEBOUNCE
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Raw and filtered level
  input wire logic raw_i,
  output logic clean_o
);

  logic [TMR_W-1:0] cnt;
  wire differs = raw_i != clean_o;
  wire settled = differs && (cnt == STABLE_CYC - 33'h1);

  // Any bounce back to the old level restarts the count
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= '0;
      clean_o <= 1'b0;
    end else begin
      cnt <= (differs && !settled) ? cnt + 33'h1 : '0;
      if (settled) begin
        clean_o <= raw_i;
      end
    end
  end

endmodule : btn_debounce

// *** test/btn_operator.sv ***
`timescale 1ns/1ps
module btn_operator
  import boot_sel_pkg::*;
(
  // Clock and commands
  input wire logic mclk_i,
  input wire logic arm_i,
  input wire logic [7:0] gap_i,
  input wire logic [7:0] hold_i,
  input wire led_t led_i,
  // Button and progress
  output logic btn_o,
  output logic done_o
);
  // Arm arrives while reset is low: that stands for holding before power-up
  initial begin
    btn_o = 1'b0;
    done_o = 1'b0;
    forever begin
      @(posedge mclk_i);
      if (arm_i) begin
        done_o <= 1'b0;
        btn_o <= 1'b1;
        @(posedge mclk_i);
        while (led_i.yellow !== 1'b1) @(posedge mclk_i);
        btn_o <= 1'b0;
        repeat (gap_i) @(posedge mclk_i);
        btn_o <= 1'b1;
        repeat (hold_i) @(posedge mclk_i);
        btn_o <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end
endmodule : btn_operator

// *** test/boot_mode_selector_bench.sv ***
`timescale 1ns/1ps
module boot_mode_selector_bench;
  import boot_sel_pkg::*;
  logic mclk_i, arst_n_i, btn, nvm_valid, setup_sel, fw_done, arm, op_done;
  logic save_dev, save_meas, drop, fw_sw, reboot, d, m, v;
  boot_mode_t nvm_mode, boot_mode;
  nvm_wr_t nvm_wr;
  sdo_wr_t sdo;
  led_t led;
  logic [7:0] gap, hold;
  logic [5:0] ev;
  logic [5:0] exp_q[$];
  logic [31:0] r;
  logic [15:0] idx;
  logic [7:0] sub;
  logic ld_valid;
  boot_mode_t ld_mode;
  int n_mismatch, tests_run, n_red, n_yel, seed, i;

  boot_mode_selector #(.REPRESS_CYC(33'd60), .HOLD_MIN_CYC(33'd40), .HOLD_MAX_CYC(33'd60),
    .SWITCH_CYC(33'd80), .DEBOUNCE_CYC(33'd4), .FLASH_HALF_CYC(24'd3)) uut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .btn_i(btn), .nvm_valid_i(nvm_valid),
    .nvm_mode_i(nvm_mode), .nvm_wr_o(nvm_wr), .sdo_wr_i(sdo), .save_dev_o(save_dev),
    .save_meas_o(save_meas), .setup_fb_sel_i(setup_sel), .setup_drop_o(drop),
    .fw_switch_o(fw_sw), .fw_done_i(fw_done), .reboot_o(reboot), .boot_mode_o(boot_mode),
    .status_indicator_led_o(led));

  btn_operator op (.mclk_i(mclk_i), .arm_i(arm), .gap_i(gap), .hold_i(hold), .led_i(led),
    .btn_o(btn), .done_o(op_done));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Storage keeps whatever the block writes; a reset loads a fresh image
  always @(posedge mclk_i) begin
    if (arst_n_i !== 1'b1) begin
      nvm_mode <= ld_mode;
      nvm_valid <= ld_valid;
    end else if (nvm_wr.req === 1'b1) begin
      nvm_mode <= nvm_wr.mode;
      nvm_valid <= 1'b1;
    end
  end

  always @(negedge mclk_i) begin
    if (led.red === 1'b1) n_red++;
    if (led.yellow === 1'b1) n_yel++;
    ev = {nvm_wr.mode, nvm_wr.req, reboot, drop, save_meas, save_dev};
    if (arst_n_i === 1'b1 && ev[4:0] !== 5'h0) begin
      if (exp_q.size() == 0) check({2'h0, ev}, 8'hff);
      else check({2'h0, ev}, {2'h0, exp_q.pop_front()});
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic do_reset(input logic val, input boot_mode_t md);
    arst_n_i <= 1'b0;
    ld_valid <= val;
    ld_mode <= md;
    repeat (6) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
  endtask : do_reset

  task automatic press_seq(input logic [7:0] g, input logic [7:0] h);
    gap <= g;
    hold <= h;
    arm <= 1'b1;
    arst_n_i <= 1'b0;
    ld_valid <= 1'b1;
    ld_mode <= MODE_SETUP;
    @(posedge mclk_i);
    arm <= 1'b0;
    repeat (5) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    n_red = 0;
    for (i = 0; i < 500 && op_done !== 1'b1; i++) @(posedge mclk_i);
    check({7'h0, op_done}, 8'h01);
  endtask : press_seq

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    seed = 56017;
    {arst_n_i, setup_sel, fw_done, arm, ld_valid} = '0;
    ld_mode = MODE_SETUP;
    sdo = '0;
    gap = 8'h0;
    hold = 8'h0;
    do_reset(1'b0, MODE_SETUP);
    check(8'(boot_mode), 8'(MODE_FIELDBUS));
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      v = r[4] | r[5];
      idx = r[1] ? (r[0] ? OBJ_SAVE_DEV_IDX : OBJ_SAVE_MEAS_IDX) : r[31:16];
      sub = r[2] ? (r[3] ? OBJ_SAVE_DEV_SUB : OBJ_SAVE_MEAS_SUB) : r[15:8];
      sdo <= '{v, idx, sub};
      // Random fields may hit a save object by chance, so judge the fields themselves
      d = v && idx == OBJ_SAVE_DEV_IDX && sub == OBJ_SAVE_DEV_SUB;
      m = v && idx == OBJ_SAVE_MEAS_IDX && sub == OBJ_SAVE_MEAS_SUB;
      if (d || m) exp_q.push_back({4'h8, m, d});
      @(posedge mclk_i);
    end
    sdo <= '0;
    repeat (4) @(posedge mclk_i);
    $display("test object writes done");
    do_reset(1'b1, MODE_SETUP);
    check(8'(boot_mode), 8'(MODE_SETUP));
    exp_q.push_back(6'h24);
    exp_q.push_back(6'h38);
    setup_sel <= 1'b1;
    @(posedge mclk_i);
    setup_sel <= 1'b0;
    @(posedge mclk_i);
    @(negedge mclk_i);
    check({7'h0, fw_sw}, 8'h01);
    r = $random(seed);
    repeat (1 + r[3:0]) @(posedge mclk_i);
    fw_done <= 1'b1;
    @(posedge mclk_i);
    fw_done <= 1'b0;
    repeat (14) @(posedge mclk_i);
    check(8'(boot_mode), 8'(MODE_FIELDBUS));
    setup_sel <= 1'b1;
    @(posedge mclk_i);
    setup_sel <= 1'b0;
    repeat (4) @(posedge mclk_i);
    check({7'h0, fw_sw}, 8'h00);
    $display("test setup request done");
    r = $random(seed);
    press_seq(8'd10 + 8'(r[3:0]), 8'd10 + 8'(r[7:4]));
    repeat (20) @(posedge mclk_i);
    check({7'h0, n_red > 0}, 8'h00);
    check({6'h0, fw_sw, boot_mode}, {7'h0, MODE_SETUP});
    $display("test short hold done");
    // Late re-press and overlong hold are both refused; only the overlong hold shows red
    for (int k = 0; k < 2; k++) begin
      press_seq(k ? 8'd80 : 8'd10, k ? 8'd50 : 8'd70);
      repeat (10) @(posedge mclk_i);
      check({7'h0, n_red > 0}, {7'h0, k == 0});
      check({6'h0, fw_sw, boot_mode}, {7'h0, MODE_SETUP});
    end
    $display("test refused sequences done");
    r = $random(seed);
    exp_q.push_back(6'h38);
    press_seq(8'd5 + 8'(r[4:0]), 8'd50 + 8'(r[7:5]));
    check({7'h0, n_red > 0}, 8'h01);
    for (i = 0; i < 10 && fw_sw !== 1'b1; i++) @(posedge mclk_i);
    check({7'h0, fw_sw}, 8'h01);
    n_yel = 0;
    for (i = 0; i < 90 && reboot !== 1'b1; i++) @(posedge mclk_i);
    check({7'h0, i < 82}, 8'h01);
    check({7'h0, n_yel > 0}, 8'h01);
    repeat (12) @(posedge mclk_i);
    check(8'(boot_mode), 8'(MODE_FIELDBUS));
    $display("test button switch done");
    check(8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule : boot_mode_selector_bench
